// file: src/cips_defs.svh
// Constants of the interrupt priority sequencer.
// Assumes inclusion by bare name from the package.
`ifndef CIPS_DEFS_SVH
`define CIPS_DEFS_SVH
`define CIPS_NSRC 8
`define CIPS_LVL_W 3
`define CIPS_NUM_W 6
`define CIPS_LVL_OFF 3'h0
`define CIPS_LVL_MAX 3'h7
`define CIPS_THR_RESET 3'h0
`define CIPS_THR_WDT 3'h7
`define CIPS_INFO_ADDR 20'h00000
`define CIPS_SWI_LO 6'h20
`define CIPS_SWI_HI 6'h3F
`define CIPS_CYC_BASE 5'h12
`define CIPS_CYC_8BIT 5'h14
`define CIPS_CYC_DBG 5'h02
`define CIPS_CYC_STEP 5'h01
`define CIPS_WAIT_MAX_CYC 5'h1E
`define CIPS_PSW_GIE 0
`define CIPS_PSW_DBG 1
`define CIPS_PSW_USP 2
`endif

// file: src/cips_pkg.sv
// Types of the interrupt priority sequencer.
// Assumes the constants header is on the include path.
`include "cips_defs.svh"
package cips_pkg;
  typedef enum logic [3:0] {
    CIPS_IDLE = 4'h0,
    CIPS_INFO = 4'h1,
    CIPS_INDET = 4'h2,
    CIPS_PUSH_PSW = 4'h3,
    CIPS_PUSH_PC = 4'h4,
    CIPS_VEC_LO = 4'h5,
    CIPS_VEC_HI = 4'h6,
    CIPS_FILL = 4'h7,
    CIPS_FETCH = 4'h8
  } cips_state_t;
  typedef enum logic [2:0] {
    CIPS_BUS_NONE = 3'h0,
    CIPS_BUS_INFO = 3'h1,
    CIPS_BUS_INDET = 3'h2,
    CIPS_BUS_STACK = 3'h3,
    CIPS_BUS_VEC = 3'h4,
    CIPS_BUS_FETCH = 3'h5
  } cips_bus_t;
  typedef struct packed {
    logic [5:0] num;
    logic [2:0] lvl;
  } cips_info_t;
  typedef struct packed {
    logic wdt;
    logic rst;
    logic dbg;
    logic step;
    logic amatch;
  } cips_special_t;
endpackage

// file: src/cips_sequencer.sv
// Maskable interrupt acceptance and CPU interrupt entry sequence.
// Assumes the instruction core marks boundaries and suspendable ops on the same clock.
// What this block does
// - Eligible only when level strictly above threshold.
// - Three-bit level; zero means source disabled.
// - Accept needs enable, request and level.
// - Enable, requests, levels, threshold stored independently.
// - Threshold n passes n+1 up; seven blocks.
// - Resolve at instruction end, start next cycle.
// - String and accumulate ops suspend for interrupts.
// - First step reads address zero for info.
// - Status word copied to hidden temporary register.
// - Clear enable, debug, stack flags; soft exception.
// - Push saved status word then program counter.
// - Load accepted level last, then fetch routine.
// - 18/19/20 cycles by parity; 8-bit twenty.
// - Debugger break two extra, step/match one.
// - Instruction wait at most thirty cycles.
// - Bus order info, indet, stacks, vectors, fetch.
// - Indeterminate cycle reads when queue accepts.
// - Watchdog sets threshold seven, reset zero.
// - Read-modify-write control writes never lose requests.
// - Enable flag set/clear by software, zero reset.
// - Hardware sets request, clears on accept.
// - Equal levels resolved by fixed hardware order.
`timescale 1ns/10ps
`include "cips_defs.svh"
module cips_sequencer
  import cips_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Peripheral sources
  input wire logic [`CIPS_NSRC-1:0] SRC_REQ_I,
  input wire logic [`CIPS_NSRC-1:0] SRC_REQ_CLR_I,
  input wire logic [`CIPS_NSRC*`CIPS_LVL_W-1:0] SRC_LVL_WDATA_I,
  input wire logic [`CIPS_NSRC-1:0] SRC_LVL_WE_I,
  // Special sources
  input wire cips_special_t SPECIAL_I,
  input wire logic SWI_I,
  input wire logic [5:0] SWI_NUM_I,
  // Status word access
  input wire logic GIE_WE_I,
  input wire logic GIE_WDATA_I,
  input wire logic THR_WE_I,
  input wire logic [2:0] THR_WDATA_I,
  input wire logic [15:0] PSW_I,
  // Instruction core
  input wire logic INSN_DONE_I,
  input wire logic SUSPENDABLE_OP_I,
  input wire logic [19:0] PC_I,
  input wire logic [19:0] SP_I,
  input wire logic [19:0] VEC_ADDR_I,
  input wire logic BUS_8BIT_I,
  input wire logic QUEUE_READY_I,
  // Outputs
  output logic GIE_O,
  output logic DBG_CLR_O,
  output logic USP_CLR_O,
  output logic [2:0] THR_O,
  output logic [`CIPS_NSRC-1:0] SRC_REQ_O,
  output logic [`CIPS_NSRC*`CIPS_LVL_W-1:0] SRC_LVL_O,
  output logic SEQ_BUSY_O,
  output logic SEQ_DONE_O,
  output cips_info_t INFO_O,
  output logic [15:0] PSW_SAVED_O,
  output cips_bus_t BUS_KIND_O,
  output logic [19:0] BUS_ADDR_O,
  output logic BUS_READ_O,
  output logic WAIT_OVER_O
);
  cips_state_t state_reg;
  logic gie_reg;
  logic [2:0] thr_reg;
  logic [`CIPS_NSRC-1:0] req_reg;
  logic [`CIPS_NSRC*`CIPS_LVL_W-1:0] lvl_reg;
  cips_info_t info_reg;
  logic [15:0] psw_tmp_reg;
  logic [4:0] cyc_reg;
  logic [4:0] cyc_total_reg;
  logic [4:0] wait_reg;
  logic soft_reg;
  logic [2:0] kind_reg;
  logic dbg_clr_reg;
  logic usp_clr_reg;
  logic done_reg;
  logic [19:0] addr_reg;
  cips_bus_t bus_reg;
  logic best_hit;
  logic [2:0] best_lvl;
  logic [5:0] best_num;
  logic boundary;
  logic take_mask;
  logic take_any;

  function automatic logic [2:0] lvl_of(input logic [`CIPS_NSRC*`CIPS_LVL_W-1:0] v, input int i);
    lvl_of = v[i*`CIPS_LVL_W +: `CIPS_LVL_W];
  endfunction

  // Lower index wins ties: fixed hardware order
  always_comb begin
    best_hit = 1'b0;
    best_lvl = `CIPS_LVL_OFF;
    best_num = 6'h00;
    for (int i = 0; i < `CIPS_NSRC; i++) begin
      if (req_reg[i] && (lvl_of(lvl_reg, i) > thr_reg) && (lvl_of(lvl_reg, i) > best_lvl)) begin
        best_hit = 1'b1;
        best_lvl = lvl_of(lvl_reg, i);
        best_num = 6'(i);
      end
    end
  end

  assign boundary = INSN_DONE_I || SUSPENDABLE_OP_I;
  assign take_mask = gie_reg && best_hit;
  assign take_any = (state_reg == CIPS_IDLE) && boundary &&
    (take_mask || SWI_I || SPECIAL_I.rst || SPECIAL_I.dbg || SPECIAL_I.wdt || SPECIAL_I.step || SPECIAL_I.amatch);

  // Enable flag, cleared on entry
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      gie_reg <= 1'b0;
    end else if (take_any) begin
      gie_reg <= 1'b0;
    end else if (GIE_WE_I) begin
      gie_reg <= GIE_WDATA_I;
    end
  end

  // Request bits: set beats clear
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      req_reg <= '0;
    end else begin
      for (int i = 0; i < `CIPS_NSRC; i++) begin
        if (SRC_REQ_I[i]) begin
          req_reg[i] <= 1'b1;
        end else if (SRC_REQ_CLR_I[i] || (take_any && take_mask && !SPECIAL_I.rst && !SPECIAL_I.dbg &&
          !SPECIAL_I.wdt && best_num == 6'(i))) begin
          req_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Level fields
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      lvl_reg <= '0;
    end else begin
      for (int i = 0; i < `CIPS_NSRC; i++) begin
        if (SRC_LVL_WE_I[i]) begin
          lvl_reg[i*`CIPS_LVL_W +: `CIPS_LVL_W] <= SRC_LVL_WDATA_I[i*`CIPS_LVL_W +: `CIPS_LVL_W];
        end
      end
    end
  end

  // Threshold, updated at the last step
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      thr_reg <= `CIPS_THR_RESET;
    end else if (state_reg == CIPS_FETCH) begin
      if (kind_reg == 3'h1) begin
        thr_reg <= info_reg.lvl;
      end else if (kind_reg == 3'h2) begin
        thr_reg <= `CIPS_THR_WDT;
      end else if (kind_reg == 3'h3) begin
        thr_reg <= `CIPS_THR_RESET;
      end
    end else if (THR_WE_I) begin
      thr_reg <= THR_WDATA_I;
    end
  end

  // Capture of the accepted source; kinds 1 mask, 2 wdt, 3 reset, 4 dbg, 5 step, 6 soft
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      info_reg <= '0;
      kind_reg <= 3'h0;
      soft_reg <= 1'b0;
      psw_tmp_reg <= 16'h0000;
      cyc_total_reg <= 5'h00;
    end else if (take_any) begin
      psw_tmp_reg <= PSW_I;
      soft_reg <= SWI_I && !take_mask && !(|SPECIAL_I) &&
        (SWI_NUM_I >= `CIPS_SWI_LO) && (SWI_NUM_I <= `CIPS_SWI_HI);
      if (SPECIAL_I.rst) begin
        kind_reg <= 3'h3;
        info_reg <= '0;
      end else if (SPECIAL_I.dbg) begin
        kind_reg <= 3'h4;
        info_reg <= '0;
      end else if (SPECIAL_I.wdt) begin
        kind_reg <= 3'h2;
        info_reg <= '0;
      end else if (take_mask) begin
        kind_reg <= 3'h1;
        info_reg <= '{num: best_num, lvl: best_lvl};
      end else if (SPECIAL_I.step || SPECIAL_I.amatch) begin
        kind_reg <= 3'h5;
        info_reg <= '0;
      end else begin
        kind_reg <= 3'h6;
        info_reg <= '{num: SWI_NUM_I, lvl: `CIPS_LVL_OFF};
      end
      cyc_total_reg <= (BUS_8BIT_I ? `CIPS_CYC_8BIT :
        5'(`CIPS_CYC_BASE + {4'h0, VEC_ADDR_I[0]} + {4'h0, SP_I[0]})) +
        (SPECIAL_I.rst ? 5'h00 : SPECIAL_I.dbg ? `CIPS_CYC_DBG :
        (!SPECIAL_I.wdt && !take_mask && (SPECIAL_I.step || SPECIAL_I.amatch)) ? `CIPS_CYC_STEP : 5'h00);
    end
  end

  // Sequence walker; fill cycles stretch the sequence to the table count
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      state_reg <= CIPS_IDLE;
      cyc_reg <= 5'h00;
    end else begin
      cyc_reg <= (state_reg == CIPS_IDLE) ? 5'h00 : 5'(cyc_reg + 5'h01);
      case (state_reg)
        CIPS_IDLE: if (take_any) state_reg <= CIPS_INFO;
        CIPS_INFO: state_reg <= CIPS_INDET;
        CIPS_INDET: state_reg <= CIPS_PUSH_PSW;
        CIPS_PUSH_PSW: state_reg <= CIPS_PUSH_PC;
        CIPS_PUSH_PC: state_reg <= CIPS_VEC_LO;
        CIPS_VEC_LO: state_reg <= CIPS_VEC_HI;
        CIPS_VEC_HI: state_reg <= CIPS_FILL;
        CIPS_FILL: if (cyc_reg >= 5'(cyc_total_reg - 5'h02)) state_reg <= CIPS_FETCH;
        CIPS_FETCH: state_reg <= CIPS_IDLE;
        default: state_reg <= CIPS_IDLE;
      endcase
    end
  end

  // Bus activity of each step
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      bus_reg <= CIPS_BUS_NONE;
      addr_reg <= 20'h00000;
    end else begin
      case (state_reg)
        CIPS_IDLE: begin
          bus_reg <= take_any ? CIPS_BUS_INFO : CIPS_BUS_NONE;
          addr_reg <= `CIPS_INFO_ADDR;
        end
        CIPS_INFO: begin
          bus_reg <= QUEUE_READY_I ? CIPS_BUS_INDET : CIPS_BUS_NONE;
          addr_reg <= PC_I;
        end
        CIPS_INDET: begin
          bus_reg <= CIPS_BUS_STACK;
          addr_reg <= 20'(SP_I - 20'h00002);
        end
        CIPS_PUSH_PSW: begin
          bus_reg <= CIPS_BUS_STACK;
          addr_reg <= 20'(SP_I - 20'h00004);
        end
        CIPS_PUSH_PC: begin
          bus_reg <= CIPS_BUS_VEC;
          addr_reg <= VEC_ADDR_I;
        end
        CIPS_VEC_LO: begin
          bus_reg <= CIPS_BUS_VEC;
          addr_reg <= 20'(VEC_ADDR_I + 20'h00002);
        end
        CIPS_FILL: begin
          bus_reg <= (cyc_reg >= 5'(cyc_total_reg - 5'h02)) ? CIPS_BUS_FETCH : CIPS_BUS_NONE;
          addr_reg <= PC_I;
        end
        default: begin
          bus_reg <= CIPS_BUS_NONE;
          addr_reg <= addr_reg;
        end
      endcase
    end
  end

  // Flag clear strobes and completion
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      dbg_clr_reg <= 1'b0;
      usp_clr_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      dbg_clr_reg <= (state_reg == CIPS_INFO);
      usp_clr_reg <= (state_reg == CIPS_INFO) && !soft_reg;
      done_reg <= (state_reg == CIPS_FETCH);
    end
  end

  // Wait monitor: pending interrupt with no boundary for too long
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      wait_reg <= 5'h00;
    end else if (state_reg != CIPS_IDLE || boundary || !take_mask) begin
      wait_reg <= 5'h00;
    end else if (wait_reg != `CIPS_WAIT_MAX_CYC) begin
      wait_reg <= 5'(wait_reg + 5'h01);
    end
  end

  assign GIE_O = gie_reg;
  assign DBG_CLR_O = dbg_clr_reg;
  assign USP_CLR_O = usp_clr_reg;
  assign THR_O = thr_reg;
  assign SRC_REQ_O = req_reg;
  assign SRC_LVL_O = lvl_reg;
  assign SEQ_BUSY_O = (state_reg != CIPS_IDLE);
  assign SEQ_DONE_O = done_reg;
  assign INFO_O = info_reg;
  assign PSW_SAVED_O = psw_tmp_reg;
  assign BUS_KIND_O = bus_reg;
  assign BUS_ADDR_O = addr_reg;
  assign BUS_READ_O = (bus_reg != CIPS_BUS_STACK) && (bus_reg != CIPS_BUS_NONE);
  assign WAIT_OVER_O = (wait_reg == `CIPS_WAIT_MAX_CYC);
endmodule

// file: test/cips_sequencer_props.sv
// Checker of the interrupt entry sequence at the top ports.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/10ps
module cips_sequencer_props
  import cips_pkg::*;
(
  // Clock, reset and core inputs
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [19:0] SP_I,
  input wire logic [19:0] VEC_ADDR_I,
  input wire logic QUEUE_READY_I,
  // Sequencer outputs
  input wire logic SEQ_BUSY_O,
  input wire logic SEQ_DONE_O,
  input wire logic GIE_O,
  input wire logic DBG_CLR_O,
  input wire cips_info_t INFO_O,
  input wire cips_bus_t BUS_KIND_O,
  input wire logic [19:0] BUS_ADDR_O,
  input wire logic BUS_READ_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [4:0] busy_cnt_reg;
  // Held until the done pulse so the length is seen there
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I || SEQ_DONE_O) begin
      busy_cnt_reg <= 5'h0;
    end else if (SEQ_BUSY_O) begin
      busy_cnt_reg <= busy_cnt_reg + 5'h1;
    end
  end
  property p_info_first;
    $rose(SEQ_BUSY_O) |-> BUS_KIND_O == CIPS_BUS_INFO && BUS_ADDR_O == 20'h00000 && BUS_READ_O;
  endproperty
  a_info_first: assert property (p_info_first) else $error("info read not first");
  property p_gie_clr;
    $rose(SEQ_BUSY_O) |-> !GIE_O;
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("enable not cleared");
  property p_dbg_clr;
    $rose(SEQ_BUSY_O) |-> ##[0:2] DBG_CLR_O;
  endproperty
  a_dbg_clr: assert property (p_dbg_clr) else $error("debug flag not cleared");
  property p_indet;
    $rose(SEQ_BUSY_O) && QUEUE_READY_I |=> BUS_KIND_O == CIPS_BUS_INDET && BUS_READ_O;
  endproperty
  a_indet: assert property (p_indet) else $error("indeterminate cycle not a read");
  property p_stack;
    BUS_KIND_O == CIPS_BUS_STACK && $past(BUS_KIND_O) != CIPS_BUS_STACK |-> BUS_ADDR_O == SP_I - 20'h2 && !BUS_READ_O;
  endproperty
  a_stack: assert property (p_stack) else $error("first push address wrong");
  property p_vec;
    BUS_KIND_O == CIPS_BUS_VEC && $past(BUS_KIND_O) == CIPS_BUS_STACK |-> BUS_ADDR_O == VEC_ADDR_I && BUS_READ_O;
  endproperty
  a_vec: assert property (p_vec) else $error("vector read out of order");
  property p_hold;
    SEQ_BUSY_O && $past(SEQ_BUSY_O) |-> $stable(INFO_O);
  endproperty
  a_hold: assert property (p_hold) else $error("info changed in sequence");
  property p_len;
    SEQ_DONE_O |-> busy_cnt_reg >= 5'h12 && busy_cnt_reg <= 5'h17;
  endproperty
  a_len: assert property (p_len) else $error("sequence length out of range");
  property p_fetch_last;
    SEQ_DONE_O |-> $past(BUS_KIND_O) == CIPS_BUS_FETCH && $past(BUS_READ_O);
  endproperty
  a_fetch_last: assert property (p_fetch_last) else $error("fetch not last step");
endmodule
bind cips_sequencer cips_sequencer_props u_cips_sequencer_props (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
  .SP_I(SP_I), .VEC_ADDR_I(VEC_ADDR_I), .QUEUE_READY_I(QUEUE_READY_I), .SEQ_BUSY_O(SEQ_BUSY_O),
  .SEQ_DONE_O(SEQ_DONE_O), .GIE_O(GIE_O), .DBG_CLR_O(DBG_CLR_O), .INFO_O(INFO_O),
  .BUS_KIND_O(BUS_KIND_O), .BUS_ADDR_O(BUS_ADDR_O), .BUS_READ_O(BUS_READ_O));

// file: test/cips_core_model.sv
// Instruction core model: marks instruction ends.
// Assumes the bench gates it and picks the gap.
`timescale 1ns/10ps
module cips_core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic [4:0] gap_i,
  output logic done_o
);
  logic [4:0] cnt_reg;
  // Gap stays under thirty so a boundary always comes in time
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !en_i) begin
      cnt_reg <= 5'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= cnt_reg >= gap_i;
      cnt_reg <= (cnt_reg >= gap_i) ? 5'h0 : cnt_reg + 5'h1;
    end
  end
endmodule

// file: test/cips_sequencer_tb.sv
// Self-checking bench of the interrupt priority sequencer.
// Assumes the core model and checker compile first.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, a); end end
module cips_sequencer_tb;
  import cips_pkg::*;
  typedef struct packed {
    logic [3:0] idx;
    logic [2:0] lvl;
    logic [2:0] thr;
    logic [4:0] cyc;
    logic usp;
  } cips_exp_t;
  logic clk = 0, rstn = 0, en = 0, insn, swi, gwe, gwd, twe, susp, b8, qr, usn;
  logic [7:0] req, rclr, lwe, sreq;
  logic [23:0] lv, slvl;
  logic [2:0] twd, thr;
  logic [5:0] swn;
  logic [15:0] psw, psws;
  logic [19:0] sp, vec, ba, pc = 20'h01234;
  logic [31:0] x = 32'hbf30, r, r2;
  logic [4:0] gap = 5'h00, ncyc = 0;
  logic gie, dbgc, uspc, busy, sdone, brd, wov;
  cips_special_t spc;
  cips_info_t info;
  cips_bus_t bk;
  cips_exp_t e, m, q[$];
  int checks = 0, fail_count = 0;
  cips_special_t sv [7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h00};
  cips_sequencer u_cips_sequencer (.REF_CLK_I(clk), .RSTN_I(rstn), .SRC_REQ_I(req), .SRC_REQ_CLR_I(rclr),
    .SRC_LVL_WDATA_I(lv), .SRC_LVL_WE_I(lwe), .SPECIAL_I(spc), .SWI_I(swi), .SWI_NUM_I(swn),
    .GIE_WE_I(gwe), .GIE_WDATA_I(gwd), .THR_WE_I(twe), .THR_WDATA_I(twd), .PSW_I(psw),
    .INSN_DONE_I(insn), .SUSPENDABLE_OP_I(susp), .PC_I(pc), .SP_I(sp), .VEC_ADDR_I(vec),
    .BUS_8BIT_I(b8), .QUEUE_READY_I(qr), .GIE_O(gie), .DBG_CLR_O(dbgc), .USP_CLR_O(uspc),
    .THR_O(thr), .SRC_REQ_O(sreq), .SRC_LVL_O(slvl), .SEQ_BUSY_O(busy), .SEQ_DONE_O(sdone),
    .INFO_O(info), .PSW_SAVED_O(psws), .BUS_KIND_O(bk), .BUS_ADDR_O(ba), .BUS_READ_O(brd),
    .WAIT_OVER_O(wov));
  cips_core_model u_cips_core_model (.clk_i(clk), .rstn_i(rstn), .en_i(en), .gap_i(gap), .done_o(insn));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic go(input cips_exp_t ex, input logic s);
    int n;
    q.push_back(ex);
    r = xs();
    gap = 5'(r % 30);
    en = !s;
    susp = s;
    for (n = 0; n < 60 && !busy; n++) @(posedge clk) #1;
    if (busy !== 1'b1) begin fail_count++; final_report(); end
    en = 0;
    susp = 0;
    spc = '0;
    swi = 0;
    for (n = 0; n < 60 && busy; n++) @(posedge clk) #1;
    if (busy !== 1'b0) begin fail_count++; final_report(); end
    @(posedge clk) #1;
  endtask
  // Results are taken at the falling edge, once the outputs settled
  always @(negedge clk) begin
    if (busy) ncyc++;
    if (uspc) usn = 1;
    if (sdone) begin
      m = q.pop_front();
      `CHK("cycles", m.cyc, ncyc)
      `CHK("threshold", m.thr, thr)
      `CHK("stack flag", m.usp, usn)
      `CHK("saved psw", psw, psws)
      if (m.idx < 4'h8) `CHK("level", m.lvl, info.lvl)
      if (m.idx < 4'h8) `CHK("number", 6'(m.idx), info.num)
      if (m.idx < 4'h8) `CHK("request", 1'b0, sreq[m.idx])
      ncyc = 0;
      usn = 0;
    end
  end
  initial begin
    {req, rclr, lwe, lv, spc, swi, swn, gwe, gwd, twe, twd, psw, susp, sp, vec, b8, qr, usn} = '0;
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    `CHK("enable", 1'b0, gie)
    for (int k = 0; k < 24; k++) begin
      r = xs();
      r2 = xs();
      {lv, req} = r;
      {psw, qr, b8, vec[0], sp[0], twd} = r2[22:0];
      sp[19:1] = 19'h00200;
      vec[19:1] = 19'h07F80;
      {gwd, gwe, twe, lwe} = {1'b0, 1'b1, 1'b1, 8'hFF};
      @(posedge clk) #1;
      {gwe, twe, lwe} = '0;
      repeat (2) @(posedge clk) #1;
      {gwd, gwe} = 2'b11;
      @(posedge clk) #1;
      gwe = 0;
      @(posedge clk) #1;
      `CHK("levels", lv, slvl)
      `CHK("threshold", twd, thr)
      `CHK("enable", 1'b1, gie)
      e.lvl = twd;
      e.idx = 4'h8;
      for (int i = 0; i < 8; i++) if (req[i] && lv[3*i+:3] > e.lvl) {e.idx, e.lvl} = {4'(i), lv[3*i+:3]};
      req = '0;
      e.thr = e.lvl;
      e.cyc = b8 ? 5'h14 : 5'h12 + 5'(sp[0]) + 5'(vec[0]);
      e.usp = 1;
      if (e.idx == 4'h8) begin
        en = 1;
        repeat (32) @(posedge clk) #1;
        en = 0;
        `CHK("refused", 1'b0, busy)
      end else begin
        repeat (31) @(posedge clk) #1;
        `CHK("wait flag", 1'b1, wov)
        go(e, k[0]);
      end
      rclr = '1;
      req = 8'h01;
      @(posedge clk) #1;
      `CHK("set over clear", 1'b1, sreq[0])
      req = '0;
      @(posedge clk) #1;
      rclr = '0;
    end
    {sp, vec, b8} = {20'h00400, 20'h0FF00, 1'b0};
    for (int k = 0; k < 7; k++) begin
      {twd, twe} = {3'h3, 1'b1};
      @(posedge clk) #1;
      twe = 0;
      e.idx = 4'h8;
      e.thr = k == 0 ? 3'h7 : k == 1 ? 3'h0 : 3'h3;
      e.cyc = 5'h12 + (k == 2 ? 5'h2 : (k == 3 || k == 4) ? 5'h1 : 5'h0);
      e.usp = k != 5;
      spc = sv[k];
      swi = k > 4;
      swn = k == 5 ? 6'h28 : 6'h05;
      go(e, 1'b0);
    end
    final_report();
  end
endmodule
